/* src/adc_if_params.svh */
`ifndef ADC_IF_PARAMS_SVH
`define ADC_IF_PARAMS_SVH
// register byte addresses on the control bus
`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define RESULT_ADDR 8'h08
// control word: internal bit clock half period, in system cycles
`define CTRL_DIV_LSB 0
`define CTRL_DIV_MSB 7
`define CTRL_RESET 8'h02
// status word fields
`define STAT_ACC_LOST 0
`define STAT_MODE_LSB 1
`define STAT_SERIAL 3
`define STAT_EXT_CLK 4
`define STAT_CONVERTING 5
`define STAT_READING 6
`define STAT_COUNT_LSB 7
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// data path sizes
`define RESULT_BITS 16
`define FIFO_DEPTH 8
// timing
`define SYS_CLK_MHZ 10
`define FAST_GAP_MAX_NS 1000000
`endif

/* src/adc_if_pkg.sv */
package adc_if_pkg;
  // conversion speed or power mode picked by the two select straps
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FAST,
    MODE_LOW_POWER,
    MODE_UNDEFINED
  } conv_mode_t;
  // serial read engine
  typedef enum logic {
    SER_IDLE,
    SER_SHIFT
  } ser_state_t;
  // static straps, synchronised
  typedef struct packed {
    logic code_format_select;
    logic fast_select;
    logic low_power_select;
    logic port_type_select;
  } strap_t;
  // shared data pins reused as serial settings
  typedef struct packed {
    logic clock_source_select;
    logic frame_marker_polarity;
    logic bit_clock_polarity;
    logic read_timing_or_chain_in;
  } serial_cfg_t;
endpackage : adc_if_pkg

/* src/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] stage1; // metastable stage, read only by stage2
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // four flops; the output moves only once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
        stage3[i] <= 1'b0;
        level_o[i] <= 1'b0;
      end else begin
        stage1[i] <= async_i[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pin_sync

/* src/result_fifo.sv */
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW:0] wr_ptr; // extra bit tells full from empty
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign count_o = wr_ptr - rd_ptr;
  assign in_ready_o = (count_o != DEPTH[AW:0]);
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage write, no reset needed
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : result_fifo

/* src/adc_if_top.sv */
// Summary of operation
// R1: code format high gives binary, low inverts msb
// R2: fast high, low power low selects fastest mode
// R3: host converts within 1 ms in fastest mode
// R4: fast select low keeps accuracy at any rate
// R5: low power high, fast low reduces power
// R6: port select low parallel, high serial
// R7: data bits zero to three always outputs
// R8: bit four becomes clock source select
// R9: external clock drives serial data timing
// R10: bit five sets frame marker polarity
// R11: bit six inverts the serial bit clock
// R12: serial result shifts out msb first
// R13: external clock updates data on active edge
// R14: read timing picks during or after conversion
// R15: chain input reaches output after sixteen periods
// R16: both low normal, both high undefined
// R17: host keeps straps stable during transfers
`timescale 1ns/1ns
`include "adc_if_params.svh"
module adc_if_top import adc_if_pkg::*; #(
  parameter int unsigned FAST_GAP_CYCLES =
    `FAST_GAP_MAX_NS * `SYS_CLK_MHZ / 1000
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic code_format_select_i,
  input wire logic fast_select_i,
  input wire logic low_power_select_i,
  input wire logic port_type_select_i,
  input wire logic conv_start_i,
  input wire logic read_req_i,
  input wire logic [15:0] result_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  input wire logic [15:0] data_pin_i,
  output logic [15:0] data_pin_o,
  output logic [15:0] data_pin_oe_b_o,
  output logic frame_marker_o,
  output conv_mode_t conv_mode_o,
  output logic converting_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int CW = $clog2(`FIFO_DEPTH) + 1;
  logic [11:0] sync_in; // everything from outside the clock domain
  logic [11:0] sync_lvl;
  strap_t strap; // synchronised straps
  serial_cfg_t scfg; // pins 4..7 read as serial settings
  logic sclk_pin; // external bit clock level
  logic conv_lvl, conv_prev, conv_rise;
  logic req_lvl, req_prev, req_rise;
  logic [15:0] fifo_data;
  logic fifo_valid, fifo_pop;
  logic [CW-1:0] fifo_count;
  logic [15:0] fmt_data; // popped word in chosen code format
  logic [15:0] par_reg; // parallel bus word
  logic [15:0] last_result; // software copy of the last word
  logic [7:0] clk_div; // internal bit clock half period
  logic acc_lost; // sticky: fastest mode interval exceeded
  logic [31:0] gap_cnt;
  ser_state_t ser_state;
  logic [15:0] shift_reg;
  logic ser_bit; // serial result out, flop
  logic [4:0] bit_cnt;
  logic [7:0] div_cnt;
  logic clk_int, lclk, lclk_prev, lrise, lfall;
  logic serial_mode, ext_clk, start_read;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_hold, w_hold, do_write, clr_acc;

  // straps, request pins and data pins 4..9 cross through four flops
  assign sync_in = {code_format_select_i, fast_select_i,
                    low_power_select_i, port_type_select_i,
                    conv_start_i, read_req_i, data_pin_i[9:4]};
  pin_sync #(.W(12)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(sync_in),
    .level_o(sync_lvl)
  );
  assign strap = sync_lvl[11:8];
  assign conv_lvl = sync_lvl[7];
  assign req_lvl = sync_lvl[6];
  assign sclk_pin = sync_lvl[5];
  // pin 8 is the serial out; pins 7..4 carry the settings
  assign scfg = {sync_lvl[0], sync_lvl[1], sync_lvl[2], sync_lvl[3]};
  assign serial_mode = strap.port_type_select; // see R6
  assign ext_clk = scfg.clock_source_select; // see R8 see R9

  // mode decode from the two select straps
  always_comb begin
    case ({strap.fast_select, strap.low_power_select})
      2'b10: conv_mode_o = MODE_FAST; // see R2
      2'b01: conv_mode_o = MODE_LOW_POWER; // see R5
      2'b00: conv_mode_o = MODE_NORMAL; // see R16
      default: conv_mode_o = MODE_UNDEFINED; // see R16
    endcase
  end

  // edge memory for request pins
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_prev <= 1'b0;
      req_prev <= 1'b0;
    end else begin
      conv_prev <= conv_lvl;
      req_prev <= req_lvl;
    end
  end
  assign conv_rise = conv_lvl && !conv_prev;
  assign req_rise = req_lvl && !req_prev;

  // conversion in progress until the core hands its word over
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converting_o <= 1'b0;
    end else if (conv_rise) begin
      converting_o <= 1'b1;
    end else if (result_valid_i && result_ready_o) begin
      converting_o <= 1'b0;
    end
  end

  // fastest mode loses accuracy if conversions come too far apart;
  // other modes never time out
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt <= 32'h0000_0000;
    end else if (conv_rise || conv_mode_o != MODE_FAST) begin
      gap_cnt <= 32'h0000_0000; // see R4
    end else if (gap_cnt != FAST_GAP_CYCLES) begin
      gap_cnt <= gap_cnt + 32'h0000_0001; // see R3
    end
  end

  // sticky flag; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_lost <= 1'b0;
    end else if (conv_mode_o == MODE_FAST &&
                 gap_cnt == FAST_GAP_CYCLES - 1 && !conv_rise) begin
      acc_lost <= 1'b1; // see R3
    end else if (clr_acc) begin
      acc_lost <= 1'b0;
    end
  end

  // results wait here; a stalled reader stalls the core
  result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_data_i(result_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .count_o(fifo_count)
  );
  // low format strap flips the msb only
  assign fmt_data = fifo_data ^ {~strap.code_format_select, 15'h0000};
  // serial start: external on the host's request, internal by read mode
  always_comb begin
    if (!serial_mode || ser_state != SER_IDLE || !fifo_valid) begin
      start_read = 1'b0;
    end else if (ext_clk) begin
      start_read = req_rise; // see R9
    end else if (scfg.read_timing_or_chain_in) begin
      start_read = converting_o; // see R14
    end else begin
      start_read = !converting_o; // see R14
    end
  end
  // parallel mode drains at once, serial only when a read starts
  assign fifo_pop = serial_mode ? start_read : fifo_valid; // see R6

  // parallel word and software copy, both formatted
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_reg <= 16'h0000;
      last_result <= 16'h0000;
    end else if (fifo_pop) begin
      par_reg <= serial_mode ? par_reg : fmt_data; // see R1
      last_result <= fmt_data; // see R1
    end
  end

  // internal bit clock: divider enable toggles it during a read only
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= 8'h00;
      clk_int <= 1'b0;
    end else if (ser_state != SER_SHIFT || ext_clk) begin
      div_cnt <= 8'h00;
      clk_int <= 1'b0;
    end else if (div_cnt + 8'h01 >= clk_div) begin
      div_cnt <= 8'h00;
      clk_int <= ~clk_int;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // logical clock: external pin undone by its polarity, or internal
  assign lclk = ext_clk ? (sclk_pin ^ scfg.bit_clock_polarity) : clk_int;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lclk_prev <= 1'b0;
    end else begin
      lclk_prev <= lclk;
    end
  end
  // polarity bit turns falling pin edges into the active ones
  assign lrise = lclk && !lclk_prev; // see R11 see R13
  assign lfall = !lclk && lclk_prev;

  // serial engine: msb first, chain input fills behind the result
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_state <= SER_IDLE;
      shift_reg <= 16'h0000;
      ser_bit <= 1'b0;
      bit_cnt <= 5'h00;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          if (start_read) begin
            shift_reg <= fmt_data; // see R12
            bit_cnt <= 5'h00;
            ser_state <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (ext_clk && !req_lvl) begin
            ser_state <= SER_IDLE; // host ended the read
          end else if (lrise && (ext_clk || bit_cnt != 5'h10)) begin
            ser_bit <= shift_reg[15]; // see R12 see R13
            // see R15
            shift_reg <= {shift_reg[14:0], scfg.read_timing_or_chain_in};
            bit_cnt <= (bit_cnt == 5'h10) ? bit_cnt : bit_cnt + 5'h01;
          end else if (lfall && !ext_clk && bit_cnt == 5'h10) begin
            ser_state <= SER_IDLE; // master frame done after last bit
          end
        end
        default: ser_state <= SER_IDLE;
      endcase
    end
  end

  // frame marker active during a read, polarity from bit five
  assign frame_marker_o = (serial_mode && ser_state == SER_SHIFT) ^
                          scfg.frame_marker_polarity; // see R10

  // pin drive: enable low means driven
  always_comb begin
    data_pin_o = par_reg;
    data_pin_oe_b_o = 16'h0000; // parallel: all driven
    if (serial_mode) begin
      data_pin_oe_b_o[7:4] = 4'hf; // settings are inputs; see R8
      data_pin_o[8] = ser_bit; // see R12
      data_pin_o[9] = clk_int ^ scfg.bit_clock_polarity; // see R11
      data_pin_oe_b_o[9] = ext_clk; // external clock comes in; see R9
    end
    data_pin_oe_b_o[3:0] = 4'h0; // see R7
  end

  // bus write: address and data held apart, then applied together
  assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid_o;
  assign clr_acc = do_write && aw_addr == `STATUS_ADDR &&
                   w_strb[0] && w_data[`STAT_ACC_LOST];
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (do_write) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (do_write) begin
        w_hold <= 1'b0;
      end
    end
  end

  // write response and the control register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
      clk_div <= `CTRL_RESET;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= `RESP_OKAY;
      case (aw_addr)
        `CTRL_ADDR: begin
          if (w_strb[0]) begin
            clk_div <= w_data[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
          end
        end
        `STATUS_ADDR, `RESULT_ADDR: ; // read only, clear done above
        default: s_axi_bresp_o <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // bus read: one cycle after the address is taken
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `RESP_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
      case (s_axi_araddr_i)
        `CTRL_ADDR: s_axi_rdata_o[7:0] <= clk_div;
        `STATUS_ADDR: begin
          s_axi_rdata_o[`STAT_ACC_LOST] <= acc_lost;
          s_axi_rdata_o[`STAT_MODE_LSB+:2] <= conv_mode_o;
          s_axi_rdata_o[`STAT_SERIAL] <= serial_mode;
          s_axi_rdata_o[`STAT_EXT_CLK] <= ext_clk;
          s_axi_rdata_o[`STAT_CONVERTING] <= converting_o;
          s_axi_rdata_o[`STAT_READING] <= ser_state == SER_SHIFT;
          s_axi_rdata_o[`STAT_COUNT_LSB+:CW] <= fifo_count;
        end
        `RESULT_ADDR: s_axi_rdata_o[15:0] <= last_result;
        default: s_axi_rresp_o <= `RESP_SLVERR;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule : adc_if_top

/* verification/adc_if_top_asserts.sv */
`timescale 1ns/1ns
module adc_if_top_asserts import adc_if_pkg::*; #(
  parameter int unsigned FAST_GAP_CYCLES = 10000
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic code_format_select_i,
  input wire logic fast_select_i,
  input wire logic low_power_select_i,
  input wire logic port_type_select_i,
  input wire logic read_req_i,
  input wire logic [15:0] result_i,
  input wire logic result_valid_i,
  input wire logic result_ready_o,
  input wire logic [15:0] data_pin_i,
  input wire logic [15:0] data_pin_o,
  input wire logic [15:0] data_pin_oe_b_o,
  input wire logic frame_marker_o,
  input wire conv_mode_t conv_mode_o
);
  // straps pass a synchroniser, so each strap relation waits six steady cycles; p_hold waits three
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_fast;
    (fast_select_i && !low_power_select_i)[*6] |-> conv_mode_o == MODE_FAST;
  endproperty
  a_fast: assert property (p_fast) else $error("fast mode missed");
  property p_low;
    (low_power_select_i && !fast_select_i)[*6]
      |-> conv_mode_o == MODE_LOW_POWER;
  endproperty
  a_low: assert property (p_low) else $error("low power missed");
  property p_norm;
    (!fast_select_i && !low_power_select_i)[*6] |-> conv_mode_o == MODE_NORMAL;
  endproperty
  a_norm: assert property (p_norm) else $error("normal missed");
  property p_low_bits;
    data_pin_oe_b_o[3:0] == 4'h0;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits");
  property p_par;
    (!port_type_select_i)[*6] |-> data_pin_oe_b_o == 16'h0;
  endproperty
  a_par: assert property (p_par) else $error("parallel bus off");
  property p_ser;
    port_type_select_i[*6]
      |-> data_pin_oe_b_o[7:4] == 4'hf && !data_pin_oe_b_o[8];
  endproperty
  a_ser: assert property (p_ser) else $error("serial pins");
  property p_clk_dir;
    (port_type_select_i && $stable(data_pin_i[4]))[*6]
      |-> data_pin_oe_b_o[9] == data_pin_i[4];
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock dir");
  property p_marker;
    (port_type_select_i && data_pin_i[4] && !read_req_i
      && $stable(data_pin_i[5]))[*6] |-> frame_marker_o == data_pin_i[5];
  endproperty
  a_marker: assert property (p_marker) else $error("marker idle");
  // data may only move after the active edge, never in the inactive half
  property p_hold;
    (port_type_select_i && data_pin_i[4] && read_req_i && $past(read_req_i, 8)
      && data_pin_i[9] == data_pin_i[6])[*3] |-> $stable(data_pin_o[8]);
  endproperty
  a_hold: assert property (p_hold) else $error("bit moved");
  property p_fmt;
    logic [15:0] v;
    (!port_type_select_i && $stable(code_format_select_i))[*6] ##0
      (result_valid_i && result_ready_o,
       v = {result_i[15] ~^ code_format_select_i, result_i[14:0]})
      |-> ##[1:12] data_pin_o == v;
  endproperty
  a_fmt: assert property (p_fmt) else $error("word format");
  c_full: cover property (!result_ready_o);
  c_frame: cover property ($fell(frame_marker_o));
  c_undef: cover property (conv_mode_o == MODE_UNDEFINED);
endmodule : adc_if_top_asserts
bind adc_if_top adc_if_top_asserts #(.FAST_GAP_CYCLES(FAST_GAP_CYCLES))
  u_adc_if_top_asserts (.*);

/* verification/link_host_model.sv */
`timescale 1ns/1ns
module link_host_model (
  input wire logic sys_clk_i,
  input wire logic sdata_i,
  output logic link_clk_o,
  output logic read_req_o
);
  // the bit clock stands still between frames
  initial begin
    link_clk_o = 1'b0;
    read_req_o = 1'b0;
  end
  // one framed read; sampling late in the period, 800 ns per bit
  task automatic read_frame(input logic pol, input int n,
    output logic [31:0] bits);
    bits = 32'h0;
    link_clk_o = pol;
    #1037;
    @(posedge sys_clk_i);
    read_req_o <= 1'b1;
    #1037;
    for (int i = 0; i < n; i++) begin
      link_clk_o = ~pol;
      #400;
      link_clk_o = pol;
      #390;
      bits = {bits[30:0], sdata_i};
      #10;
    end
    #1000;
    @(posedge sys_clk_i);
    read_req_o <= 1'b0;
  endtask : read_frame
endmodule : link_host_model

/* verification/tb_adc_if_top.sv */
`timescale 1ns/1ns
`include "adc_if_params.svh"
module tb_adc_if_top import adc_if_pkg::*;;
  logic sys_clk_i, rst_b_i, code_format_select_i, fast_select_i;
  logic low_power_select_i, port_type_select_i, conv_start_i, read_req_i;
  logic result_valid_i, result_ready_o, frame_marker_o, converting_o;
  logic [15:0] result_i, data_pin_i, data_pin_o, data_pin_oe_b_o, drv;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d, bits;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, link_clk;
  conv_mode_t conv_mode_o;
  int n_mismatch, cmp_count;
  // released pins read the bench's level, driven pins read back
  assign data_pin_i = (data_pin_oe_b_o & {drv[15:10], link_clk, drv[8:0]})
    | (~data_pin_oe_b_o & data_pin_o);
  adc_if_top #(.FAST_GAP_CYCLES(50)) u_adc_if_top (.*);
  link_host_model u_link_host_model (.sys_clk_i(sys_clk_i),
    .sdata_i(data_pin_o[8]), .link_clk_o(link_clk), .read_req_o(read_req_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // watchdog far beyond the whole sequence
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  function automatic bit miss(input bit f);
    cmp_count++;
    return f;
  endfunction : miss
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic settle;
    repeat (10) @(posedge sys_clk_i);
  endtask : settle
  // one write; handshakes sampled mid-cycle, released after the edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] rs);
    logic da, dw, h;
    {da, dw, h} = 3'h0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    for (int i = 0; i < 40 && !h; i++) begin
      @(negedge sys_clk_i);
      da |= s_axi_awready_o;
      dw |= s_axi_wready_o;
      h = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (da) s_axi_awvalid_i <= 1'b0;
      if (dw) s_axi_wvalid_i <= 1'b0;
      if (h) s_axi_bready_i <= 1'b0;
    end
    if (!h) bad("write hung");
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    logic da, h;
    {da, h} = 2'h0;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    for (int i = 0; i < 40 && !h; i++) begin
      @(negedge sys_clk_i);
      da |= s_axi_arready_o;
      h = s_axi_rvalid_o;
      {v, rs} = {s_axi_rdata_o, s_axi_rresp_o};
      @(posedge sys_clk_i);
      if (da) s_axi_arvalid_i <= 1'b0;
      if (h) s_axi_rready_i <= 1'b0;
    end
    if (!h) bad("read hung");
  endtask : axr
  task automatic push(input logic [15:0] w);
    logic h;
    h = 1'b0;
    @(posedge sys_clk_i);
    result_i <= w;
    result_valid_i <= 1'b1;
    for (int i = 0; i < 40 && !h; i++) begin
      @(negedge sys_clk_i);
      h = result_ready_o;
      @(posedge sys_clk_i);
    end
    result_valid_i <= 1'b0;
    if (!h) bad("word refused");
  endtask : push
  // reset value, read-back and an unmapped place
  task t_regs;
    axr(`CTRL_ADDR, d, r);
    if (miss(d[7:0] !== `CTRL_RESET)) bad("ctrl reset value");
    axw(`CTRL_ADDR, 32'h5, r);
    axr(`CTRL_ADDR, d, r);
    if (miss(d[7:0] !== 8'h05)) bad("ctrl read back");
    axr(8'h1c, d, r);
    if (miss(r !== `RESP_SLVERR)) bad("unmapped read");
    axw(8'h1c, 32'h0, r);
    if (miss(r !== `RESP_SLVERR)) bad("unmapped write");
  endtask : t_regs
  // every strap pair, including the undefined one
  task t_modes;
    conv_mode_t tbl [4];
    tbl = '{MODE_NORMAL, MODE_LOW_POWER, MODE_FAST, MODE_UNDEFINED};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      {fast_select_i, low_power_select_i} <= 2'(i);
      settle;
      if (miss(conv_mode_o !== tbl[i])) bad("mode decode");
    end
  endtask : t_modes
  // short gaps keep the flag clear, a long one sets it
  task t_gap;
    {fast_select_i, low_power_select_i} <= 2'b10;
    repeat (3) begin
      repeat (30) @(posedge sys_clk_i);
      conv_start_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      conv_start_i <= 1'b0;
    end
    axr(`STATUS_ADDR, d, r);
    if (miss(d[`STAT_ACC_LOST] !== 1'b0)) bad("flag too early");
    if (miss(converting_o !== 1'b1)) bad("no conversion");
    repeat (60) @(posedge sys_clk_i);
    axr(`STATUS_ADDR, d, r);
    if (miss(d[`STAT_ACC_LOST] !== 1'b1)) bad("gap missed");
    fast_select_i <= 1'b0;
    settle;
    axw(`STATUS_ADDR, 32'h1, r);
    repeat (60) @(posedge sys_clk_i);
    axr(`STATUS_ADDR, d, r);
    if (miss(d[`STAT_ACC_LOST] !== 1'b0)) bad("flag stuck");
  endtask : t_gap
  // one word in each code format on the parallel bus
  task t_par;
    logic [15:0] e;
    port_type_select_i <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      code_format_select_i <= f[0];
      settle;
      push(16'h8001);
      e = f ? 16'h8001 : 16'h0001;
      repeat (4) @(negedge sys_clk_i);
      if (miss(data_pin_o !== e)) bad("parallel word");
      if (miss(data_pin_oe_b_o !== 16'h0)) bad("bus off");
      axr(`RESULT_ADDR, d, r);
      if (miss(d[15:0] !== e)) bad("result register");
    end
  endtask : t_par
  // fill to refusal, two framed reads, one per clock polarity
  task t_ser_ext;
    drv[7:4] <= 4'b1001;
    port_type_select_i <= 1'b1;
    settle;
    for (int i = 0; i < 8; i++)
      push(16'ha5c0 + 16'(i));
    @(negedge sys_clk_i);
    if (miss(result_ready_o !== 1'b0)) bad("full buffer took more");
    axr(`STATUS_ADDR, d, r);
    if (miss(d[`STAT_COUNT_LSB +: 4] !== 4'h8)) bad("buffer count");
    for (int p = 0; p < 2; p++) begin
      drv[6] <= p[0];
      settle;
      u_link_host_model.read_frame(p[0], 18, bits);
      if (miss(bits[17:0] !== {16'ha5c0 + 16'(p), 2'b11}))
        bad("serial frame");
    end
    port_type_select_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    axr(`STATUS_ADDR, d, r);
    if (miss(d[`STAT_COUNT_LSB +: 4] !== 4'h0)) bad("buffer not drained");
  endtask : t_ser_ext
  // internal clock, read after conversion, active-low marker
  task t_ser_int;
    int n;
    logic prev;
    n = 0;
    drv[7:4] <= 4'b0010;
    port_type_select_i <= 1'b1;
    settle;
    @(negedge sys_clk_i);
    if (miss(frame_marker_o !== 1'b1)) bad("idle marker");
    push(16'h1234);
    for (int i = 0; i < 200 && frame_marker_o; i++)
      @(negedge sys_clk_i);
    prev = data_pin_o[9];
    for (int i = 0; i < 400 && !frame_marker_o; i++) begin
      @(negedge sys_clk_i);
      n += int'(data_pin_o[9] && !prev);
      prev = data_pin_o[9];
    end
    if (miss(n !== 16)) bad("internal clock edges");
  endtask : t_ser_int
  initial begin
    {rst_b_i, code_format_select_i, fast_select_i} = 3'h0;
    {low_power_select_i, port_type_select_i, conv_start_i} = 3'h0;
    {result_valid_i, s_axi_awvalid_i, s_axi_wvalid_i} = 3'h0;
    {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 3'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, result_i, drv} = 48'h0;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_modes;
    t_gap;
    t_par;
    t_ser_ext;
    t_ser_int;
    wrap_up;
  end
endmodule : tb_adc_if_top
